// ---- inc/link_initiator_cfg.svh ----
// Constants for the die link initiator
`ifndef LINK_INITIATOR_CFG_SVH
`define LINK_INITIATOR_CFG_SVH
`define CMD_IDLE 4'h0
`define CMD_WRITE 4'h1
`define CMD_READ 4'h2
`define EOT_ACK_CODE 4'ha
`define DIV_BY1 2'h0
`define DIV_BY4 2'h3
`define TIMEOUT_SCALE 4
`define WIDTH_FOUR 1'b0
`define LINK_PINS_NARROW 6
`define LINK_PINS_WIDE 10
`endif

// ---- inc/link_initiator_pkg.sv ----
// Types shared by the die link initiator modules
package link_initiator_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_ACK, ST_DONE
  } link_state_type;
  typedef logic [1:0] clk_div_type;
endpackage

// ---- inc/link_clock_if.sv ----
// Carrier between the transfer engine and the link clock generator
`timescale 1ns/10ps
`default_nettype none
interface link_clock_if;
  logic [1:0] divider;
  logic run;
  logic halt;
  logic rise;
  logic fall;
  logic level;
  logic parked;
  modport gen (input divider, input run, input halt, output rise, output fall, output level,
    output parked);
  modport user (output divider, output run, output halt, input rise, input fall, input level,
    input parked);
endinterface
`default_nettype wire

// ---- rtl/link_clock_gen.sv ----
// Link clock divider with stop parking
`timescale 1ns/10ps
`default_nettype none
`include "link_initiator_cfg.svh"
module link_clock_gen (
  input wire logic clk,
  input wire logic rst_n,
  link_clock_if.gen lc
);
  import link_initiator_pkg::*;
  typedef struct packed {
    logic [2:0] cnt;
    logic level;
  } gen_state_type;
  gen_state_type s_q, s_d;
  logic [2:0] half;
  always_comb begin
    half = {1'b0, lc.divider} + 3'h1;
    s_d = s_q;
    lc.rise = 1'b0;
    lc.fall = 1'b0;
    if (!lc.run) begin
      s_d = '0;
    end else if (s_q.cnt + 3'h1 >= half) begin
      s_d.cnt = '0;
      if (s_q.level) begin
        s_d.level = 1'b0;
        lc.fall = 1'b1;
      end else if (!lc.halt) begin
        s_d.level = 1'b1;
        lc.rise = 1'b1;
      end
    end else begin
      s_d.cnt = s_q.cnt + 3'h1;
    end
  end
  // Divide by one: a low phase plus a high phase of one cycle each
  assign lc.level = s_q.level;
  assign lc.parked = !s_q.level;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Three-stage synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } sync_state_type;
  sync_state_type s_q, s_d;
  always_comb begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.out[i] = s_q.s3[i];
      end
    end
  end
  assign dout = s_q.out;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/link_initiator.sv ----
// Die link initiator: CPU window accesses to link transactions
`timescale 1ns/10ps
`default_nettype none
`include "link_initiator_cfg.svh"
module link_initiator #(
  parameter int TIMEOUT_BITS = 4
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CFG_WRITE,
  input wire logic CFG_ENABLE,
  input wire logic CFG_WIDE,
  input wire logic CFG_HALT_IN_STOP,
  input wire link_initiator_pkg::clk_div_type CFG_DIVIDER,
  input wire logic [TIMEOUT_BITS-1:0] CFG_TIMEOUT,
  input wire logic CFG_IRQ_ENABLE,
  input wire logic SPECIAL_MODE,
  input wire logic STOP_MODE,
  input wire logic REQ_VALID,
  input wire logic REQ_WRITE,
  input wire logic REQ_NONBLOCK,
  input wire logic REQ_WORD,
  input wire logic [7:0] REQ_ADDR,
  input wire logic [15:0] REQ_WDATA,
  output logic REQ_READY,
  output logic [15:0] RSP_RDATA,
  output logic RSP_ERROR,
  output logic BUSY,
  output logic ERROR_FLAG,
  input wire logic ERROR_CLEAR,
  output logic ERROR_NMI,
  output logic TARGET_IRQ,
  output logic LINK_ENABLE,
  output logic LINK_WIDE,
  output logic LINK_HALT_IN_STOP,
  output link_initiator_pkg::clk_div_type LINK_DIVIDER,
  output logic LINK_CLOCK_OUT,
  output logic LINK_CLOCK_OE_N,
  input wire logic [7:0] LINK_DATA_IN,
  output logic [7:0] LINK_DATA_OUT,
  output logic [7:0] LINK_DATA_OE_N,
  output logic [7:0] LINK_DATA_PULLDOWN,
  output logic [7:0] LINK_DATA_OWNED,
  input wire logic TARGET_IRQ_IN,
  output logic TARGET_IRQ_PULLDOWN,
  output logic TARGET_IRQ_OWNED
);
  import link_initiator_pkg::*;
  typedef struct packed {
    link_state_type st;
    logic cfg_locked;
    logic enable;
    logic wide;
    logic halt;
    clk_div_type divider;
    logic write;
    logic word;
    logic nonblock;
    logic [7:0] addr;
    logic [15:0] data;
    logic [2:0] nib;
    logic [TIMEOUT_BITS+`TIMEOUT_SCALE-1:0] timer;
    logic [7:0] dout;
    logic drive;
    logic err;
    logic [15:0] rdata;
    logic rsp_err;
  } init_state_type;
  init_state_type s_q, s_d;
  logic [8:0] pins_sync;
  logic [2:0] beats;
  logic [7:0] lane;
  logic timed_out;
  link_clock_if lc();
  link_clock_gen u_clk (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .lc(lc.gen)
  );
  pin_sync #(.WIDTH(9)) u_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .din({TARGET_IRQ_IN, LINK_DATA_IN}),
    .dout(pins_sync)
  );
  // Beats per access: one per byte in wide mode, two nibbles per byte otherwise, doubled for a word
  function automatic logic [2:0] beat_count(input logic wide, input logic word);
    logic [2:0] b;
    b = wide ? 3'h1 : 3'h2;
    beat_count = word ? {b[1:0], 1'b0} : b;
  endfunction
  // Slice of the shift word driven this beat, low nibble first
  function automatic logic [7:0] beat_lane(input logic wide, input logic [15:0] d);
    beat_lane = wide ? d[7:0] : {4'h0, d[3:0]};
  endfunction
  assign beats = beat_count(s_q.wide, s_q.word);
  assign lane = beat_lane(s_q.wide, s_q.data);
  assign timed_out = (s_q.timer == '0);
  assign lc.divider = s_q.divider;
  assign lc.run = s_q.enable;
  assign lc.halt = STOP_MODE && s_q.halt;
  always_comb begin
    s_d = s_q;
    if (CFG_WRITE && (!s_q.cfg_locked || SPECIAL_MODE)) begin
      s_d.cfg_locked = 1'b1;
      s_d.enable = CFG_ENABLE;
      s_d.wide = CFG_WIDE;
      s_d.halt = CFG_HALT_IN_STOP;
      s_d.divider = CFG_DIVIDER;
    end
    // Set wins over software clear
    if (ERROR_CLEAR) begin
      s_d.err = 1'b0;
    end
    if (s_q.st != ST_IDLE && s_q.st != ST_DONE && lc.rise) begin
      s_d.timer = s_q.timer - 1'b1;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        s_d.drive = 1'b1;
        s_d.dout = {4'h0, `CMD_IDLE};
        if (REQ_VALID && s_q.enable && !(STOP_MODE && s_q.halt) && lc.fall) begin
          s_d.write = REQ_WRITE || REQ_NONBLOCK;
          s_d.nonblock = REQ_NONBLOCK;
          s_d.word = REQ_WORD;
          s_d.addr = REQ_ADDR;
          s_d.data = REQ_WDATA;
          s_d.timer = {CFG_TIMEOUT, {`TIMEOUT_SCALE{1'b1}}};
          s_d.rsp_err = 1'b0;
          s_d.dout = {4'h0, (REQ_WRITE || REQ_NONBLOCK) ? `CMD_WRITE : `CMD_READ};
          s_d.st = ST_CMD;
        end
      end
      ST_CMD: begin
        if (lc.fall) begin
          s_d.dout = s_q.wide ? s_q.addr : {4'h0, s_q.addr[3:0]};
          s_d.nib = 3'h1;
          s_d.st = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (lc.fall) begin
          if (!s_q.wide && s_q.nib == 3'h1) begin
            s_d.dout = {4'h0, s_q.addr[7:4]};
            s_d.nib = 3'h2;
          end else if (s_q.write) begin
            s_d.dout = lane;
            s_d.data = s_q.wide ? {8'h00, s_q.data[15:8]} : {4'h0, s_q.data[15:4]};
            s_d.nib = 3'h1;
            s_d.st = ST_WDATA;
          end else begin
            s_d.drive = 1'b0;
            s_d.nib = 3'h0;
            s_d.st = ST_RDATA;
          end
        end
      end
      ST_WDATA: begin
        if (lc.fall) begin
          if (s_q.nib < beats) begin
            s_d.dout = lane;
            s_d.data = s_q.wide ? {8'h00, s_q.data[15:8]} : {4'h0, s_q.data[15:4]};
            s_d.nib = s_q.nib + 3'h1;
          end else begin
            s_d.drive = 1'b0;
            s_d.st = ST_ACK;
          end
        end
      end
      ST_RDATA: begin
        // Sample four or eight lines
        // Sampled at the end of the high phase so the synchroniser delay is covered
        // Limitation: divide by one and divide by two are too short for reads
        if (lc.fall) begin
          if (s_q.wide) begin
            s_d.data = {pins_sync[7:0], s_q.data[15:8]};
          end else begin
            s_d.data = {pins_sync[3:0], s_q.data[15:4]};
          end
          s_d.nib = s_q.nib + 3'h1;
          if (s_q.nib + 3'h1 == beats) begin
            s_d.st = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        if (lc.fall && pins_sync[3:0] == `EOT_ACK_CODE) begin
          s_d.rdata = s_q.word ? s_q.data : {8'h00, s_q.data[15:8]};
          s_d.st = ST_DONE;
        end
      end
      ST_DONE: begin
        s_d.st = ST_IDLE;
        s_d.drive = 1'b1;
        s_d.dout = '0;
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (s_q.st != ST_IDLE && s_q.st != ST_DONE && timed_out) begin
      s_d.err = 1'b1;
      s_d.rsp_err = 1'b1;
      s_d.st = ST_DONE;
    end
    if (STOP_MODE && s_q.halt && s_q.st == ST_IDLE) begin
      s_d.dout = '0;
    end
  end
  // Stall until done or non-blocking accept
  assign REQ_READY = s_q.enable && (s_q.st == ST_DONE && !s_q.nonblock
    || s_q.st == ST_IDLE && REQ_NONBLOCK && lc.fall && !(STOP_MODE && s_q.halt));
  assign BUSY = (s_q.st != ST_IDLE);
  assign RSP_RDATA = s_q.rdata;
  assign RSP_ERROR = s_q.rsp_err;
  assign ERROR_FLAG = s_q.err;
  assign ERROR_NMI = s_q.err;
  assign TARGET_IRQ = s_q.enable && CFG_IRQ_ENABLE && pins_sync[8];
  assign TARGET_IRQ_PULLDOWN = s_q.enable;
  assign TARGET_IRQ_OWNED = s_q.enable;
  assign LINK_ENABLE = s_q.enable;
  assign LINK_WIDE = s_q.wide;
  assign LINK_HALT_IN_STOP = s_q.halt;
  assign LINK_DIVIDER = s_q.divider;
  assign LINK_CLOCK_OUT = s_q.enable && lc.level;
  assign LINK_CLOCK_OE_N = !s_q.enable;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lane
      logic used;
      assign used = s_q.enable && (g < 4 || s_q.wide);
      assign LINK_DATA_OWNED[g] = used;
      assign LINK_DATA_OUT[g] = used && s_q.drive && s_q.dout[g];
      assign LINK_DATA_OE_N[g] = !(used && s_q.drive);
      assign LINK_DATA_PULLDOWN[g] = used && !s_q.drive;
    end
  endgenerate
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule
`default_nettype wire

// ---- sim/link_initiator_sva.sv ----
// Port assertions for the die link initiator
`timescale 1ns/10ps
`default_nettype none
module link_initiator_sva (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CFG_WRITE,
  input wire logic CFG_IRQ_ENABLE,
  input wire logic SPECIAL_MODE,
  input wire logic STOP_MODE,
  input wire logic REQ_VALID,
  input wire logic REQ_NONBLOCK,
  input wire logic REQ_READY,
  input wire logic RSP_ERROR,
  input wire logic BUSY,
  input wire logic ERROR_FLAG,
  input wire logic ERROR_NMI,
  input wire logic TARGET_IRQ,
  input wire logic LINK_ENABLE,
  input wire logic LINK_WIDE,
  input wire logic LINK_HALT_IN_STOP,
  input wire link_initiator_pkg::clk_div_type LINK_DIVIDER,
  input wire logic LINK_CLOCK_OUT,
  input wire logic LINK_CLOCK_OE_N,
  input wire logic [7:0] LINK_DATA_OUT,
  input wire logic [7:0] LINK_DATA_OE_N,
  input wire logic [7:0] LINK_DATA_PULLDOWN,
  input wire logic [7:0] LINK_DATA_OWNED,
  input wire logic TARGET_IRQ_PULLDOWN,
  input wire logic TARGET_IRQ_OWNED
);
  import link_initiator_pkg::*;
  typedef struct packed {logic wr; logic last; logic seen; logic [3:0] cnt;} mon_type;
  mon_type mon_q, mon_d;
  // Phase length is only trusted after a full phase under a steady setting
  always_comb begin
    mon_d = mon_q;
    mon_d.wr = mon_q.wr | CFG_WRITE;
    mon_d.last = LINK_CLOCK_OUT;
    mon_d.cnt = (LINK_CLOCK_OUT != mon_q.last) ? 4'h1 : mon_q.cnt + 4'h1;
    mon_d.seen = LINK_ENABLE && !CFG_WRITE && !(STOP_MODE && LINK_HALT_IN_STOP) &&
      (mon_q.seen || LINK_CLOCK_OUT != mon_q.last);
  end
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) mon_q <= '0;
    else mon_q <= mon_d;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  a_irq_gate: assert property (TARGET_IRQ |-> CFG_IRQ_ENABLE && LINK_ENABLE)
    else $error("target interrupt passed while gated");
  a_clk_off: assert property ((!LINK_ENABLE)[*3] |-> !LINK_CLOCK_OUT && LINK_CLOCK_OE_N)
    else $error("link clock active while disabled");
  a_lane_owner: assert property (LINK_DATA_OWNED ==
    (LINK_ENABLE ? (LINK_WIDE ? 8'hff : 8'h0f) : 8'h00)) else $error("wrong lanes owned");
  a_pull_input: assert property (LINK_DATA_PULLDOWN == (LINK_DATA_OWNED & LINK_DATA_OE_N))
    else $error("pull-down wrong on data lines");
  a_irq_pin: assert property (TARGET_IRQ_OWNED == LINK_ENABLE && TARGET_IRQ_PULLDOWN == LINK_ENABLE)
    else $error("interrupt pin setup wrong");
  a_cfg_lock: assert property (mon_q.wr && !SPECIAL_MODE |=>
    $stable({LINK_ENABLE, LINK_WIDE, LINK_HALT_IN_STOP, LINK_DIVIDER})) else $error("config rewritten");
  a_nb_busy: assert property (REQ_VALID && REQ_NONBLOCK && REQ_READY |=> BUSY)
    else $error("busy missing after non-blocking write");
  a_err_nmi: assert property ($rose(RSP_ERROR) |-> ##[0:2] ERROR_FLAG && ERROR_NMI)
    else $error("error interrupt missing");
  a_clk_phase: assert property (mon_q.seen && LINK_CLOCK_OUT != mon_q.last |->
    mon_q.cnt == {2'h0, LINK_DIVIDER} + 4'h1) else $error("link clock phase wrong");
  a_stop_park: assert property ((STOP_MODE && LINK_HALT_IN_STOP)[*8] |->
    !LINK_CLOCK_OUT && LINK_DATA_OUT == 8'h00) else $error("link not parked in stop");
  c_timeout: cover property (REQ_READY && RSP_ERROR);
  c_nonblock: cover property (REQ_READY && REQ_NONBLOCK);
  c_irq: cover property (TARGET_IRQ);
endmodule
bind link_initiator link_initiator_sva chk_u (.*);
`default_nettype wire

// ---- sim/link_target_model.sv ----
// Behavioural target die at the far end of the link
`timescale 1ns/10ps
`default_nettype none
module link_target_model (
  input wire logic lclk,
  input wire logic [7:0] oe_n,
  input wire logic [7:0] dout,
  input wire logic wide,
  input wire logic word,
  input wire logic [15:0] rdata,
  input wire logic mute,
  input wire logic [1:0] late,
  output logic [7:0] din
);
  logic act = 0, rd = 0, ackd = 0, drv = 0;
  logic [7:0] val = 8'h00;
  logic [15:0] sh = 16'h0000;
  int n = 0, w = 0;
  // released lines sit at the pull-down level
  always_comb din = ~oe_n & dout | (drv ? val & oe_n : 8'h00);
  // a command on the lines opens a transaction
  always @(posedge lclk) if (!act && !oe_n[0] && dout[3:0] != 4'h0) begin
    act = 1;
    rd = dout[3:0] == 4'h2;
    n = 0;
    w = late;
    sh = rdata;
  end
  // read beats low part first, then the acknowledge code
  always @(negedge lclk) begin
    #1;
    drv = 0;
    if (act && oe_n[0]) begin
      if (rd && n < (wide ? 1 : 2) * (word ? 2 : 1)) begin
        drv = 1;
        val = wide ? sh[7:0] : {4'h0, sh[3:0]};
        sh = wide ? sh >> 8 : sh >> 4;
        n++;
      end else if (w > 0) w--;
      else if (!mute && !ackd) begin
        drv = 1;
        val = 8'h0a;
        ackd = 1;
      end else begin
        act = 0;
        ackd = 0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- sim/link_initiator_tb.sv ----
// Self-checking bench for the die link initiator
`timescale 1ns/10ps
`default_nettype none
module link_initiator_tb;
  import link_initiator_pkg::*;
  logic REF_CLK = 0, RSTN = 0, CFG_WRITE = 0, CFG_ENABLE = 0, CFG_WIDE = 0, CFG_HALT_IN_STOP = 0;
  logic CFG_IRQ_ENABLE = 0, SPECIAL_MODE = 0, STOP_MODE = 0, REQ_VALID = 0, REQ_WRITE = 0;
  logic REQ_NONBLOCK = 0, REQ_WORD = 0, ERROR_CLEAR = 0, TARGET_IRQ_IN = 0, mute = 0;
  logic [1:0] late = 2'h0;
  clk_div_type CFG_DIVIDER = 2'h3, LINK_DIVIDER;
  logic [3:0] CFG_TIMEOUT = 4'h0;
  logic [7:0] REQ_ADDR = 8'h00, LINK_DATA_IN, LINK_DATA_OUT, LINK_DATA_OE_N, LINK_DATA_PULLDOWN;
  logic [7:0] LINK_DATA_OWNED;
  logic [15:0] REQ_WDATA = 16'h0000, rdata = 16'h0000, RSP_RDATA;
  logic REQ_READY, RSP_ERROR, BUSY, ERROR_FLAG, ERROR_NMI, TARGET_IRQ, LINK_ENABLE, LINK_WIDE;
  logic LINK_HALT_IN_STOP, LINK_CLOCK_OUT, LINK_CLOCK_OE_N, TARGET_IRQ_PULLDOWN, TARGET_IRQ_OWNED;
  logic [7:0] beats[$];
  int fails = 0, n_tests = 0, cyc = 0;
  link_initiator #(.TIMEOUT_BITS(4)) dut_u (.*);
  link_target_model tgt_u (.lclk(LINK_CLOCK_OUT), .oe_n(LINK_DATA_OE_N), .dout(LINK_DATA_OUT),
    .wide(LINK_WIDE), .word(REQ_WORD), .rdata(rdata), .mute(mute), .late(late), .din(LINK_DATA_IN));
  initial forever #12.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  // Zero beats are idle filler, so test values avoid zero nibbles
  always @(posedge LINK_CLOCK_OUT) begin
    #1;
    if (BUSY === 1'b1 && LINK_DATA_OE_N[0] === 1'b0 && (LINK_DATA_OUT & LINK_DATA_OWNED) != 0)
      beats.push_back(LINK_DATA_OUT & LINK_DATA_OWNED);
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge REF_CLK);
    #2;
  endtask
  task automatic cfg(logic en, wd, halt, clk_div_type dv, logic sp);
    {CFG_ENABLE, CFG_WIDE, CFG_HALT_IN_STOP, CFG_DIVIDER, SPECIAL_MODE} = {en, wd, halt, dv, sp};
    CFG_WRITE = 1;
    tick(1);
    CFG_WRITE = 0;
    SPECIAL_MODE = 0;
    tick(2);
  endtask
  task automatic req(logic wr, nb, wd, logic [7:0] a, logic [15:0] d, int lim);
    int k;
    k = 0;
    {REQ_WRITE, REQ_NONBLOCK, REQ_WORD, REQ_ADDR, REQ_WDATA} = {wr, nb, wd, a, d};
    REQ_VALID = 1;
    beats.delete();
    while (REQ_READY !== 1'b1 && k < lim) begin
      @(posedge REF_CLK);
      #2;
      k++;
    end
    @(posedge REF_CLK);
    #2;
    REQ_VALID = 0;
    check("answer", k < lim, 1);
    tick(2);
  endtask
  task automatic cmp_beats(logic [7:0] e[$]);
    check("beat count", beats.size(), e.size());
    foreach (e[i]) check("beat", beats[i], e[i]);
  endtask
  task automatic t_reset();
    check("reset", {LINK_CLOCK_OUT, LINK_CLOCK_OE_N, LINK_DATA_OWNED, TARGET_IRQ_OWNED}, 11'h200);
  endtask
  task automatic t_write(logic wd);
    req(1'b1, 1'b0, 1'b0, 8'h5a, 16'h003c, 400);
    check("write error", RSP_ERROR, 0);
    if (wd) cmp_beats({8'h01, 8'h5a, 8'h3c});
    else cmp_beats({8'h01, 8'h0a, 8'h05, 8'h0c, 8'h03});
  endtask
  task automatic t_config();
    cfg(1'b1, 1'b0, 1'b0, 2'h3, 1'b0);
    check("narrow", LINK_DATA_OWNED, 8'h0f);
    cfg(1'b0, 1'b1, 1'b1, 2'h0, 1'b0);
    check("locked", {LINK_ENABLE, LINK_WIDE, LINK_DIVIDER}, 4'hb);
    cfg(1'b1, 1'b1, 1'b0, 2'h3, 1'b1);
    check("wide", LINK_DATA_OWNED, 8'hff);
    t_write(1'b1);
    cfg(1'b1, 1'b0, 1'b0, 2'h3, 1'b1);
  endtask
  task automatic t_read();
    rdata = 16'hbeef;
    req(1'b0, 1'b0, 1'b1, 8'hc3, 16'h0000, 400);
    check("read data", RSP_RDATA, 16'hbeef);
    cmp_beats({8'h02, 8'h03, 8'h0c});
  endtask
  task automatic t_nonblock();
    int k;
    late = 2'h3;
    req(1'b1, 1'b1, 1'b1, 8'h5a, 16'h3c5a, 12);
    check("busy", BUSY, 1);
    for (k = 0; k < 600 && BUSY !== 1'b0; k++) tick(1);
    check("link done", {k < 600, RSP_ERROR}, 2'h2);
    cmp_beats({8'h01, 8'h0a, 8'h05, 8'h0a, 8'h05, 8'h0c, 8'h03});
    late = 2'h0;
  endtask
  task automatic t_timeout();
    mute = 1;
    req(1'b1, 1'b0, 1'b0, 8'h5a, 16'h003c, 600);
    check("timeout", {RSP_ERROR, ERROR_FLAG, ERROR_NMI}, 3'h7);
    mute = 0;
    ERROR_CLEAR = 1;
    tick(1);
    ERROR_CLEAR = 0;
    tick(1);
    check("cleared", ERROR_NMI, 0);
  endtask
  task automatic t_irq();
    TARGET_IRQ_IN = 1;
    tick(8);
    check("irq gated", TARGET_IRQ, 0);
    CFG_IRQ_ENABLE = 1;
    tick(8);
    check("irq passed", TARGET_IRQ, 1);
    TARGET_IRQ_IN = 0;
    tick(8);
    check("irq idle", TARGET_IRQ, 0);
  endtask
  task automatic t_divider();
    realtime t0;
    for (int d = 0; d < 4; d++) begin
      cfg(1'b1, 1'b0, 1'b0, 2'(d), 1'b1);
      repeat (2) @(posedge LINK_CLOCK_OUT);
      t0 = $realtime;
      @(posedge LINK_CLOCK_OUT);
      check("period", int'(($realtime - t0) / 25.0), 2 * d + 2);
    end
  endtask
  task automatic t_stop();
    cfg(1'b1, 1'b0, 1'b1, 2'h3, 1'b1);
    STOP_MODE = 1;
    tick(10);
    check("stopped", {LINK_CLOCK_OUT, LINK_DATA_OUT}, 9'h000);
    STOP_MODE = 0;
    @(posedge LINK_CLOCK_OUT);
    tick(1);
    check("woken", LINK_DATA_OUT, 8'h00);
    cfg(1'b0, 1'b0, 1'b0, 2'h3, 1'b1);
    check("off", {LINK_CLOCK_OE_N, LINK_DATA_OWNED, TARGET_IRQ_OWNED}, 10'h200);
  endtask
  task automatic complete_run();
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    tick(8);
    RSTN = 1;
    tick(1);
    t_reset();
    t_config();
    t_write(1'b0);
    t_read();
    t_nonblock();
    t_timeout();
    t_irq();
    t_divider();
    t_stop();
    complete_run();
  end
endmodule
`default_nettype wire
